// ### hdl/acr_top.sv
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module acr_top
  import acr_pkg::*;
(
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        arst_n,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Hardware trigger pin.
  input  wire logic        hw_trigger_in,
  // Analog core.
  output logic             conv_start,
  output logic             conv_abort,
  output logic             conv_power_on,
  output logic      [4:0]  conv_channel,
  output logic      [1:0]  conv_resolution,
  input  wire logic        conv_end,
  input  wire logic [11:0] conv_data,
  // Interrupt.
  output logic             conv_done_irq
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0]  ctrl_one_q;
  logic [7:0]  ctrl_two_q;
  logic [7:0]  cmp_high_q;
  logic [7:0]  cmp_low_q;
  logic [1:0]  mode_q;
  logic [11:0] result_q;
  logic        done_q;
  logic        active_q;
  logic        lock_q;
  logic        cont_run_q;
  logic        irq_q;
  logic [2:0]  trig_sync_q;
  logic [31:0] prdata_q;
  acr_state_e  state_q;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire acc      = psel & penable;
  wire wr       = acc & pwrite;
  wire rd       = acc & ~pwrite;
  wire hit_one  = (paddr == OFS_CTRL_ONE);
  wire hit_two  = (paddr == OFS_CTRL_TWO);
  wire hit_rh   = (paddr == OFS_RES_HIGH);
  wire hit_rl   = (paddr == OFS_RES_LOW);
  wire hit_ch   = (paddr == OFS_CMP_HIGH);
  wire hit_cl   = (paddr == OFS_CMP_LOW);
  wire hit_cfg  = (paddr == OFS_CONFIG);
  wire hit_any  = hit_one | hit_two | hit_rh | hit_rl | hit_ch | hit_cl | hit_cfg;
  wire wr_one   = wr & hit_one;
  wire rd_high  = rd & hit_rh;
  wire rd_low   = rd & hit_rl;
  wire wr_two   = wr & hit_two;
  wire wr_ch    = wr & hit_ch;
  wire wr_cl    = wr & hit_cl;
  wire wr_cfg   = wr & hit_cfg;
  // Read data is taken in the setup cycle, so outside 8-bit mode a high byte read stops loads from then on until the low byte is read.
  wire rd_high_setup = psel & ~pwrite & hit_rh;

  assign pready  = 1'b1;
  assign pslverr = acc & ~hit_any;
  assign prdata  = prdata_q;

  // ****************************************************************
  // Field views
  // ****************************************************************
  wire [4:0] channel_select    = ctrl_one_q[4:0];
  wire       done_irq_enable   = ctrl_one_q[BIT_IRQ_EN];
  wire       continuous_enable = ctrl_one_q[BIT_CONT_EN];
  wire       trigger_select    = ctrl_two_q[BIT_TRIG_SEL];
  wire       compare_enable    = ctrl_two_q[BIT_CMP_EN];
  wire       compare_ge_select = ctrl_two_q[BIT_CMP_GE];
  wire [4:0] new_channel       = pwdata[4:0];

  // Masks the upper bits away according to resolution.
  function automatic logic [11:0] fit_width(input logic [11:0] v, input logic [1:0] m);
    logic [11:0] r;
    r = v;
    if (m == ACR_MODE_10) begin
      r[11:10] = 2'h0;
    end else if (m != ACR_MODE_12) begin
      r[11:8] = 4'h0;
    end
    return r;
  endfunction

  // ****************************************************************
  // Compare
  // ****************************************************************
  // High compare use.
  wire [11:0] cmp_value  = fit_width({cmp_high_q[3:0], cmp_low_q}, mode_q);
  wire [11:0] conv_value = fit_width(conv_data, mode_q);
  wire        is_below   = conv_value < cmp_value;
  wire        cmp_true   = compare_ge_select ? ~is_below : is_below;
  wire        event_ok   = ~compare_enable | cmp_true;
  wire [11:0] diff       = fit_width(12'(conv_value - cmp_value), mode_q);
  wire [11:0] load_value = compare_enable ? diff : conv_value;

  // ****************************************************************
  // Conversion sequencing
  // ****************************************************************
  // Trigger pin crosses in from outside, so two stages precede the edge detect.
  wire trig_rise = trig_sync_q[1] & ~trig_sync_q[2];
  wire chan_ok   = (channel_select != CHAN_OFF) && (channel_select != CHAN_RESERVED);
  wire new_ok    = (new_channel != CHAN_OFF);
  wire sw_start  = wr_one & ~trigger_select & new_ok;
  // A write to control one in the same cycle wins over a pin edge, so the abort sticks.
  wire hw_start  = trig_rise & trigger_select & chan_ok & (state_q == ACR_IDLE) & ~cont_run_q & ~wr_one;
  wire done_now  = (state_q == ACR_CONV) & conv_end & ~wr_one;
  wire restart   = done_now & continuous_enable & chan_ok;
  wire start     = sw_start | hw_start | restart;
  wire can_load  = ~(lock_q | rd_high_setup) | (mode_q == ACR_MODE_8);
  wire load      = done_now & event_ok & can_load;

  assign conv_start      = start;
  assign conv_abort      = wr_one & (state_q == ACR_CONV);
  assign conv_power_on   = (state_q == ACR_CONV) & chan_ok;
  assign conv_channel    = channel_select;
  assign conv_resolution = mode_q;
  assign conv_done_irq   = irq_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ACR_IDLE;
    end else begin
      case (state_q)
        ACR_IDLE: begin
          if (start) begin
            state_q <= ACR_CONV;
          end
        end
        ACR_CONV: begin
          if (wr_one && !sw_start) begin
            state_q <= ACR_IDLE;
          end else if (done_now && !restart) begin
            state_q <= ACR_IDLE;
          end
        end
        default: begin
          state_q <= ACR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      active_q <= 1'b0;
    end else if (start) begin
      active_q <= 1'b1;
    end else if (done_now || conv_abort) begin
      active_q <= 1'b0;
    end
  end

  // Remembers a continuous run armed by the hardware trigger.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cont_run_q <= 1'b0;
    end else if (wr_one) begin
      cont_run_q <= 1'b0;
    end else if (hw_start && continuous_enable) begin
      cont_run_q <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      trig_sync_q <= 3'h0;
    end else begin
      trig_sync_q <= {trig_sync_q[1:0], hw_trigger_in};
    end
  end

  // ****************************************************************
  // Status, result and interrupt
  // ****************************************************************
  // Done flag set.
  // Done flag clear; a completion in the same cycle as a read wins.
  wire done_set = done_now & event_ok;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      done_q <= 1'b0;
    end else if (done_set) begin
      done_q <= 1'b1;
    end else if (wr_one || rd_low) begin
      done_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (done_q | done_set) & ~(wr_one | (rd_low & ~done_set)) & done_irq_enable;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      result_q <= 12'h000;
    end else if (load) begin
      result_q <= load_value;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lock_q <= 1'b0;
    end else if (rd_low) begin
      lock_q <= 1'b0;
    end else if (rd_high && mode_q != ACR_MODE_8) begin
      lock_q <= 1'b1;
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  // Bit 7 of control one reads back the done flag, so it is never stored.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_one_q <= RST_CTRL_ONE;
    end else if (wr_one) begin
      ctrl_one_q <= {1'b0, pwdata[6:0]};
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_two_q <= RST_BYTE;
    end else if (wr_two) begin
      ctrl_two_q <= {1'b0, pwdata[6:4], 4'h0};
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cmp_high_q <= RST_BYTE;
    end else if (wr_ch) begin
      cmp_high_q <= {4'h0, pwdata[3:0]};
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cmp_low_q <= RST_BYTE;
    end else if (wr_cl) begin
      cmp_low_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= RST_MODE;
    end else if (wr_cfg) begin
      mode_q <= pwdata[3:2];
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Unmapped addresses read as zero.
  function automatic logic [7:0] read_byte(
    input logic [11:0] a,
    input logic [7:0]  one,
    input logic [7:0]  two,
    input logic [7:0]  rh,
    input logic [7:0]  rl,
    input logic [7:0]  ch,
    input logic [7:0]  cl,
    input logic [7:0]  cfg
  );
    logic [7:0] b;
    if (a == OFS_CTRL_ONE) begin
      b = one;
    end else if (a == OFS_CTRL_TWO) begin
      b = two;
    end else if (a == OFS_RES_HIGH) begin
      b = rh;
    end else if (a == OFS_RES_LOW) begin
      b = rl;
    end else if (a == OFS_CMP_HIGH) begin
      b = ch;
    end else if (a == OFS_CMP_LOW) begin
      b = cl;
    end else if (a == OFS_CONFIG) begin
      b = cfg;
    end else begin
      b = 8'h00;
    end
    return b;
  endfunction

  wire [7:0] view_one = {done_q, ctrl_one_q[6:0]};
  wire [7:0] view_two = {active_q, ctrl_two_q[6:0]};
  wire [7:0] view_rh  = {4'h0, result_q[11:8]};
  wire [7:0] view_rl  = result_q[7:0];
  wire [7:0] view_cfg = {4'h0, mode_q, 2'h0};
  wire [7:0] rd_byte  = read_byte(paddr, view_one, view_two, view_rh, view_rl, cmp_high_q, cmp_low_q, view_cfg);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= {24'h000000, rd_byte};
    end
  end

endmodule

`default_nettype wire

// ### hdl/acr_pkg.sv
package acr_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [11:0] OFS_CTRL_ONE  = 12'h000;
  localparam logic [11:0] OFS_CTRL_TWO  = 12'h004;
  localparam logic [11:0] OFS_RES_HIGH  = 12'h008;
  localparam logic [11:0] OFS_RES_LOW   = 12'h00c;
  localparam logic [11:0] OFS_CMP_HIGH  = 12'h010;
  localparam logic [11:0] OFS_CMP_LOW   = 12'h014;
  localparam logic [11:0] OFS_CONFIG    = 12'h018;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_DONE_FLAG   = 7;
  localparam int BIT_IRQ_EN      = 6;
  localparam int BIT_CONT_EN     = 5;
  localparam int BIT_ACTIVE      = 7;
  localparam int BIT_TRIG_SEL    = 6;
  localparam int BIT_CMP_EN      = 5;
  localparam int BIT_CMP_GE      = 4;

  // ****************************************************************
  // Values after reset and codes
  // ****************************************************************
  localparam logic [4:0] CHAN_OFF       = 5'h1f;
  localparam logic [4:0] CHAN_RESERVED  = 5'h1c;
  localparam logic [4:0] CHAN_REF_HIGH  = 5'h1d;
  localparam logic [4:0] CHAN_REF_LOW   = 5'h1e;
  localparam logic [4:0] CHAN_LAST_EXT  = 5'h1b;
  localparam logic [7:0] RST_CTRL_ONE   = 8'h1f;
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [1:0] RST_MODE       = 2'h0;

  typedef enum logic [1:0] {
    ACR_MODE_8  = 2'h0,
    ACR_MODE_12 = 2'h1,
    ACR_MODE_10 = 2'h2
  } acr_res_e;

  typedef enum {
    ACR_IDLE,
    ACR_CONV
  } acr_state_e;

endpackage

// ### verification/acr_top_checker.sv
`timescale 1ns/100ps
`default_nettype none
module acr_top_checker
  import acr_pkg::*;
(
  // Clock, reset and bus.
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Core side and interrupt.
  input wire logic        conv_start,
  input wire logic        conv_abort,
  input wire logic        conv_power_on,
  input wire logic [1:0]  conv_resolution,
  input wire logic        conv_end,
  input wire logic        conv_done_irq
);
  // ****************************************************************
  // Access decode and shadow bits
  // ****************************************************************
  wire logic acc = psel && penable;
  wire logic wr1 = acc && pwrite && paddr == OFS_CTRL_ONE;
  wire logic wr2 = acc && pwrite && paddr == OFS_CTRL_TWO;
  wire logic wrc = acc && pwrite && paddr == OFS_CONFIG;
  wire logic rdl = acc && !pwrite && paddr == OFS_RES_LOW;
  logic trig_q;
  logic cont_q;
  // Shadows are only needed to qualify starts, not to model the block.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      trig_q <= 1'b0;
      cont_q <= 1'b0;
    end else begin
      if (wr2) trig_q <= pwdata[BIT_TRIG_SEL];
      if (wr1) cont_q <= pwdata[BIT_CONT_EN];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_sw_start; wr1 && pwdata[4:0] != CHAN_OFF && !trig_q |-> conv_start; endproperty
  a_sw_start: assert property (p_sw_start) else $error("no start on write");
  property p_off; wr1 && pwdata[4:0] == CHAN_OFF |-> !conv_start ##1 !conv_power_on; endproperty
  a_off: assert property (p_off) else $error("converter not off");
  property p_abort; wr1 && conv_power_on && !conv_end |-> conv_abort; endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_idle; conv_end && !cont_q && !trig_q && !wr1 |=> !conv_power_on; endproperty
  a_idle: assert property (p_idle) else $error("not idle after single");
  property p_cont; conv_end && cont_q && conv_power_on && !wr1 |-> ##[0:2] conv_start; endproperty
  a_cont: assert property (p_cont) else $error("no repeat");
  property p_irq; $rose(conv_done_irq) |-> $past(conv_end); endproperty
  a_irq: assert property (p_irq) else $error("irq without completion");
  property p_clr_low; rdl && !conv_end |=> !conv_done_irq; endproperty
  a_clr_low: assert property (p_clr_low) else $error("done not cleared");
  property p_res; wrc |=> conv_resolution == $past(pwdata[3:2]); endproperty
  a_res: assert property (p_res) else $error("mode not taken");
endmodule
bind acr_top acr_top_checker u_chk (.clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .conv_start, .conv_abort, .conv_power_on, .conv_resolution, .conv_end, .conv_done_irq);
`default_nettype wire

// ### verification/acr_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module acr_core_model (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        arst_n,
  // Commands and bench settings.
  input  wire logic        conv_start,
  input  wire logic        conv_abort,
  input  wire logic [11:0] value,
  input  wire logic [7:0]  lat,
  // Answer.
  output logic             conv_end,
  output logic      [11:0] conv_data
);
  logic [7:0] cnt_q;
  // Data toggles outside the valid cycle, so a late sample is caught.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q     <= 8'h00;
      conv_end  <= 1'b0;
      conv_data <= 12'h000;
    end else begin
      conv_end  <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_start) begin
        cnt_q <= lat;
      end else if (conv_abort) begin
        cnt_q <= 8'h00;
      end else if (cnt_q == 8'h01) begin
        cnt_q     <= 8'h00;
        conv_end  <= 1'b1;
        conv_data <= value;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/adc_control_result_compare_test.sv
`timescale 1ns/100ps
`default_nettype none
module adc_control_result_compare_test;
  import acr_pkg::*;
  logic clock = 1'b0;
  logic arst_n, psel, penable, pwrite, pready, pslverr, hw_trigger_in, err;
  logic conv_start, conv_abort, conv_power_on, conv_end, conv_done_irq;
  logic [11:0] paddr, conv_data, value;
  logic [31:0] pwdata, prdata, rd, n0;
  logic [31:0] n_start = 32'h0;
  logic [4:0]  conv_channel;
  logic [1:0]  conv_resolution;
  logic [7:0]  lat;
  logic [1:0]  md[3] = '{ACR_MODE_8, ACR_MODE_12, ACR_MODE_10};
  logic [31:0] hx[3] = '{32'h0, 32'ha, 32'h2};
  int n_errors = 0;
  int n_checks = 0;
  always #12.5 clock = ~clock;
  acr_top dut (.clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .hw_trigger_in, .conv_start, .conv_abort, .conv_power_on, .conv_channel, .conv_resolution,
    .conv_end, .conv_data, .conv_done_irq);
  acr_core_model core (.clock, .arst_n, .conv_start, .conv_abort, .value, .lat, .conv_end, .conv_data);
  always @(posedge clock) if (conv_start === 1'b1) n_start <= n_start + 32'h1;
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic wait_end;
    int i;
    i = 0;
    while (conv_end !== 1'b1 && i < 200) begin
      @(posedge clock);
      i++;
    end
    chk({31'h0, conv_end}, 32'h1);
    repeat (2) @(posedge clock);
  endtask
  task automatic conv(input logic [11:0] v, input logic [7:0] c);
    value <= v;
    apb(1'b1, OFS_CTRL_ONE, {24'h0, c});
    wait_end;
  endtask
  task automatic close_out;
    if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    close_out;
  end
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    {arst_n, psel, penable, pwrite, hw_trigger_in} = 5'h0;
    {paddr, pwdata, value, lat} = {12'h0, 32'h0, 12'h0, 8'h4};
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    rchk(OFS_CTRL_ONE, 32'h1f);
    rchk(OFS_CTRL_TWO, 32'h0);
    rchk(OFS_RES_HIGH, 32'h0);
    rchk(OFS_CMP_HIGH, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, OFS_CONFIG, {28'h0, md[m], 2'b00});
      conv(12'habc, 8'h45);
      chk({31'h0, conv_done_irq}, 32'h1);
      rchk(OFS_CTRL_ONE, 32'hc5);
      rchk(OFS_RES_HIGH, hx[m]);
      rchk(OFS_RES_LOW, 32'hbc);
      rchk(OFS_CTRL_ONE, 32'h45);
    end
    conv(12'h3cd, 8'h05);
    rchk(OFS_RES_HIGH, 32'h3);
    conv(12'h1ee, 8'h05);
    rchk(OFS_RES_LOW, 32'hcd);
    apb(1'b1, OFS_CONFIG, 32'h0);
    conv(12'h011, 8'h05);
    rchk(OFS_RES_HIGH, 32'h0);
    conv(12'h022, 8'h05);
    rchk(OFS_RES_LOW, 32'h22);
    apb(1'b1, OFS_CONFIG, 32'h4);
    apb(1'b1, OFS_CMP_HIGH, 32'h1);
    apb(1'b1, OFS_CMP_LOW, 32'h0);
    apb(1'b1, OFS_CTRL_TWO, 32'h20);
    conv(12'h0ff, 8'h05);
    rchk(OFS_CTRL_ONE, 32'h85);
    rchk(OFS_RES_HIGH, 32'hf);
    rchk(OFS_RES_LOW, 32'hff);
    conv(12'h200, 8'h05);
    rchk(OFS_CTRL_ONE, 32'h05);
    rchk(OFS_RES_LOW, 32'hff);
    apb(1'b1, OFS_CTRL_TWO, 32'h30);
    conv(12'h200, 8'h05);
    rchk(OFS_RES_HIGH, 32'h1);
    rchk(OFS_RES_LOW, 32'h0);
    apb(1'b1, OFS_CONFIG, 32'h0);
    conv(12'h005, 8'h05);
    rchk(OFS_RES_LOW, 32'h5);
    apb(1'b1, OFS_CTRL_TWO, 32'h0);
    lat <= 8'd20;
    n0 = n_start;
    apb(1'b1, OFS_CTRL_ONE, 32'h25);
    rchk(OFS_CTRL_TWO, 32'h80);
    repeat (100) @(posedge clock);
    chk({31'h0, (n_start - n0) > 32'd3}, 32'h1);
    apb(1'b1, OFS_CTRL_ONE, 32'h5f);
    n0 = n_start;
    repeat (60) @(posedge clock);
    chk(n_start, n0);
    rchk(OFS_CTRL_TWO, 32'h0);
    rchk(OFS_CTRL_ONE, 32'h5f);
    lat <= 8'd4;
    apb(1'b1, OFS_CTRL_TWO, 32'h40);
    apb(1'b1, OFS_CTRL_ONE, 32'h03);
    n0 = n_start;
    repeat (5) @(posedge clock);
    chk(n_start, n0);
    chk({27'h0, conv_channel}, 32'h3);
    hw_trigger_in <= 1'b1;
    wait_end;
    hw_trigger_in <= 1'b0;
    repeat (30) @(posedge clock);
    chk(n_start, n0 + 32'h1);
    chk({31'h0, conv_power_on}, 32'h0);
    rchk(OFS_CTRL_ONE, 32'h83);
    apb(1'b1, OFS_CTRL_TWO, 32'h0);
    n0 = n_start;
    apb(1'b1, OFS_CTRL_ONE, 32'h1c);
    @(posedge clock);
    chk({31'h0, conv_power_on}, 32'h0);
    chk(n_start, n0 + 32'h1);
    close_out;
  end
endmodule
`default_nettype wire
